// >>> hw/pwt_sync.v
/*
 * two-flop synchroniser with edge detect on the second stage.
 * assumes the input is asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module pwt_sync (
    input wire core_clk,
    input wire srst,
    input wire asyncIn,
    output wire syncLevel,
    output wire syncRise,
    output wire syncFall
);

// ----------------------------------------------------------------
// synchroniser stages
// ----------------------------------------------------------------
reg stage1;
reg stage2;
reg stage3;

// stage1 is read only by stage2, to contain metastability
always @(posedge core_clk) begin
    if (srst) begin
        stage1 <= 1'b0;
        stage2 <= 1'b0;
        stage3 <= 1'b0;
    end else begin
        stage1 <= asyncIn;
        stage2 <= stage1;
        stage3 <= stage2;
    end
end

assign syncLevel = stage2;
assign syncRise = stage2 & ~stage3;
assign syncFall = ~stage2 & stage3;

endmodule // pwt_sync

`default_nettype wire

// >>> hw/pwt_timer.v
/*
 * timer pair b: two 8-bit down counters with reload latches,
 * external pulse width measurement on timer 4 and pwm out of
 * timers 3 and 4, plus overflow and pin-edge request bits.
 * assumes an apb master on core_clk; counter pins are async.
 */
// Our own choices: the address map and the APB interface to the registers.
//
// Contract
// RL1: with stop bit clear, timer decrements by one per count source.
// RL2: stop bits reset to 0; counter pin not source; measure mode off.
// RL3: on overflow timer loads latch value minus one.
// RL4: edge register bit picks high or low level as measuring period.
// RL5: pulse width equals initial value minus stopped count.
// RL6: software rewrites initial value before each new measurement.
// RL7: timer overflow sets its request bit; enable bit gates acceptance.
// RL8: counter pin active edge sets its request bit; enable gates it.
// RL9: measurement ends at closing pin edge or software stop write.
// RL10: software stops timer 4, configures, writes value, then starts.
// RL11: level bit 0 counts while pulse high, 1 while low.
// RL12: software never counts timer 4 from its own measured pin.
// RL13: pwm mode uses timers 3 and 4 to drive pwm output pin.
// RL14: after reset timers count but pwm output stays low.
// RL15: pwm start: output low, timer 3 counts, timer 4 stopped.
// RL16: timer 3 overflow: output high, timer 3 stops, timer 4 runs.
// RL17: timer 4 overflow: output low, timer 3 runs, timer 4 stops.
// RL18: timer 3 value sets low width, timer 4 value high width.
// RL19: pwm counting continues until software sets the stop bit.
// RL20: software sets pwm bit first; timer 4 not fed by timer 3.
// RL21: pwm write to running timer updates latch only, else both.
// RL22: counter pins are synchronised before edge or level use.
`timescale 1ns/1ps
`default_nettype none
`include "pwt_consts.vh"

module pwt_timer #(
    parameter WIDTH = 8
) (
    input wire core_clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire counter_pin_a,
    input wire counter_pin_b,
    output reg pwm_output_pin,
    output wire [3:0] irqPending
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
wire pinA;
wire pinARise;
wire pinAFall;
wire pinB;
wire pinBRise;
wire pinBFall;

// RL22 pin synchronisers
pwt_sync syncA (
    .core_clk(core_clk),
    .srst(srst),
    .asyncIn(counter_pin_a),
    .syncLevel(pinA),
    .syncRise(pinARise),
    .syncFall(pinAFall)
);

pwt_sync syncB (
    .core_clk(core_clk),
    .srst(srst),
    .asyncIn(counter_pin_b),
    .syncLevel(pinB),
    .syncRise(pinBRise),
    .syncFall(pinBFall)
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [WIDTH-1:0] timer3;
reg [WIDTH-1:0] timer4;
reg [WIDTH-1:0] latch3;
reg [WIDTH-1:0] latch4;
reg [7:0] timer_pair_b_mode_reg;
reg [7:0] edge_polarity_select_reg;
reg [3:0] irqReq;
reg [3:0] irqEn;
reg [7:0] prescDiv;
reg [7:0] prescCnt;
reg pwmPhaseHigh;
reg pwmActive;
reg measArmed;

wire busWrite = psel & penable & pwrite;
wire wrT3 = busWrite & (paddr == `PWT_OFS_TIMER3);
wire wrT4 = busWrite & (paddr == `PWT_OFS_TIMER4);
wire wrMode = busWrite & (paddr == `PWT_OFS_MODE);
wire pwmMode = timer_pair_b_mode_reg[`PWT_MODE_PWM];
wire measMode = timer_pair_b_mode_reg[`PWT_MODE_MEAS];
wire stop3 = timer_pair_b_mode_reg[`PWT_MODE_STOP3];
wire stop4 = timer_pair_b_mode_reg[`PWT_MODE_STOP4];
wire [1:0] src4 = timer_pair_b_mode_reg[`PWT_MODE_SRC4_HI:`PWT_MODE_SRC4_LO];

// ----------------------------------------------------------------
// count sources
// ----------------------------------------------------------------
// prescaler tick is the internal clock source shared by both timers
wire prescTick = (prescCnt == 8'h00);

always @(posedge core_clk) begin
    if (srst) begin
        prescCnt <= `PWT_PRESC_RST;
    end else if (prescTick) begin
        prescCnt <= prescDiv;
    end else begin
        prescCnt <= prescCnt - 8'h01;
    end
end

// active edge of each pin: 1 rising, 0 falling
wire edgeA = edge_polarity_select_reg[`PWT_EDGE_A] ? pinARise : pinAFall;
wire edgeB = edge_polarity_select_reg[`PWT_EDGE_B] ? pinBRise : pinBFall;

// RL2 reset source is prescaler, not a counter pin
wire tick3 = timer_pair_b_mode_reg[`PWT_MODE_SRC3] ? edgeB : prescTick;

// measured pin and its level select
wire measPin = edge_polarity_select_reg[`PWT_EDGE_MEASPIN] ? pinB : pinA;
wire measLowSel = edge_polarity_select_reg[`PWT_EDGE_MEASPIN] ?
    edge_polarity_select_reg[`PWT_EDGE_B] : edge_polarity_select_reg[`PWT_EDGE_A];
wire measPinRise = edge_polarity_select_reg[`PWT_EDGE_MEASPIN] ? pinBRise : pinARise;
wire measPinFall = edge_polarity_select_reg[`PWT_EDGE_MEASPIN] ? pinBFall : pinAFall;

// RL4 RL11 level gate: 0 counts while high, 1 while low
wire measGate = measLowSel ? ~measPin : measPin;
// RL9 closing edge of the selected level
wire measClose = measLowSel ? measPinRise : measPinFall;

// timer 3 overflow feeds the timer 4 source mux, so it is declared first
wire ovf3;
reg tick4Raw;
always @* begin
    case (src4)
        `PWT_SRC4_PRESC: tick4Raw = prescTick;
        `PWT_SRC4_CNTR: tick4Raw = edgeB;
        default: tick4Raw = ovf3;
    endcase
end

// ----------------------------------------------------------------
// run enables and overflows
// ----------------------------------------------------------------
// RL15 RL16 RL17 pwm alternates which timer runs
wire run3 = ~stop3 & (~pwmActive | ~pwmPhaseHigh);
wire run4Base = ~stop4 & (~pwmActive | pwmPhaseHigh);
// measurement gates timer 4 with the selected pulse level
wire run4 = run4Base & (~measMode | (measArmed & measGate));
assign ovf3 = run3 & tick3 & (timer3 == {WIDTH{1'b0}});
wire ovf4 = run4 & tick4Raw & (timer4 == {WIDTH{1'b0}});

// ----------------------------------------------------------------
// timer 3
// ----------------------------------------------------------------
// RL21 pwm write to a running timer only hits the latch
wire load3 = wrT3 & ~(pwmActive & run3);
wire load4 = wrT4 & ~(pwmActive & run4Base);

always @(posedge core_clk) begin
    if (srst) begin
        timer3 <= `PWT_TIMER_RST;
        latch3 <= `PWT_TIMER_RST;
    end else begin
        if (wrT3) begin
            latch3 <= pwdata[WIDTH-1:0];
        end
        if (load3) begin
            timer3 <= pwdata[WIDTH-1:0];
        end else if (ovf3) begin
            // RL3 reload latch minus one
            timer3 <= latch3 - {{(WIDTH-1){1'b0}}, 1'b1};
        end else if (run3 & tick3) begin
            // RL1 decrement by one
            timer3 <= timer3 - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
end

// ----------------------------------------------------------------
// timer 4
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (srst) begin
        timer4 <= `PWT_TIMER_RST;
        latch4 <= `PWT_TIMER_RST;
    end else begin
        if (wrT4) begin
            latch4 <= pwdata[WIDTH-1:0];
        end
        if (load4) begin
            timer4 <= pwdata[WIDTH-1:0];
        end else if (ovf4) begin
            // RL3 reload latch minus one
            timer4 <= latch4 - {{(WIDTH-1){1'b0}}, 1'b1};
        end else if (run4 & tick4Raw) begin
            // RL1 RL5 count kept when stopped gives the width
            timer4 <= timer4 - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
end

// ----------------------------------------------------------------
// measurement arm and pwm sequencer
// ----------------------------------------------------------------
// arm when timer 4 starts; disarm at the closing edge so the count holds
always @(posedge core_clk) begin
    if (srst) begin
        measArmed <= 1'b0;
    end else if (wrMode & ~pwdata[`PWT_MODE_STOP4] & pwdata[`PWT_MODE_MEAS]) begin
        measArmed <= 1'b1;
    end else if (measMode & measArmed & measClose) begin
        // RL9 closing edge ends counting
        measArmed <= 1'b0;
    end
end

// RL13 RL14 pwm waveform only while pwm mode is selected
always @(posedge core_clk) begin
    if (srst) begin
        pwmActive <= 1'b0;
        pwmPhaseHigh <= 1'b0;
        pwm_output_pin <= 1'b0;
    end else if (~pwmMode) begin
        pwmActive <= 1'b0;
        pwmPhaseHigh <= 1'b0;
        pwm_output_pin <= 1'b0;
    end else begin
        pwmActive <= 1'b1;
        if (~pwmActive) begin
            // RL15 start low with timer 3 running
            pwmPhaseHigh <= 1'b0;
            pwm_output_pin <= 1'b0;
        end else if (ovf3 & ~pwmPhaseHigh) begin
            // RL16 RL18 low phase over
            pwmPhaseHigh <= 1'b1;
            pwm_output_pin <= 1'b1;
        end else if (ovf4 & pwmPhaseHigh) begin
            // RL17 RL18 high phase over
            pwmPhaseHigh <= 1'b0;
            pwm_output_pin <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// software registers
// ----------------------------------------------------------------
// RL2 RL19 stop bits reset clear; counting holds once set
always @(posedge core_clk) begin
    if (srst) begin
        timer_pair_b_mode_reg <= `PWT_MODE_RST;
        edge_polarity_select_reg <= `PWT_EDGE_RST;
        irqEn <= 4'h0;
        prescDiv <= `PWT_PRESC_RST;
    end else if (busWrite) begin
        case (paddr)
            `PWT_OFS_MODE: timer_pair_b_mode_reg <= pwdata[7:0];
            `PWT_OFS_EDGE: edge_polarity_select_reg <= pwdata[7:0];
            `PWT_OFS_IEN: irqEn <= pwdata[3:0];
            `PWT_OFS_PRESC: prescDiv <= pwdata[7:0];
            default: prescDiv <= prescDiv;
        endcase
    end
end

// RL7 RL8 request bits; set wins over write-one-to-clear
wire [3:0] irqSet = {edgeB, edgeA, ovf4, ovf3};
wire [3:0] irqClr = (busWrite & (paddr == `PWT_OFS_IRQ)) ? pwdata[3:0] : 4'h0;

always @(posedge core_clk) begin
    if (srst) begin
        irqReq <= 4'h0;
    end else begin
        irqReq <= (irqReq & ~irqClr) | irqSet;
    end
end

// enable gates acceptance only, the request bit records regardless
assign irqPending = irqReq & irqEn;

// ----------------------------------------------------------------
// apb read path
// ----------------------------------------------------------------
wire mapped = (paddr == `PWT_OFS_TIMER3) | (paddr == `PWT_OFS_TIMER4) |
    (paddr == `PWT_OFS_MODE) | (paddr == `PWT_OFS_EDGE) | (paddr == `PWT_OFS_IRQ) |
    (paddr == `PWT_OFS_IEN) | (paddr == `PWT_OFS_PRESC);

// zero wait states; unmapped addresses answer with an error
assign pready = 1'b1;
assign pslverr = psel & penable & ~mapped;

// read data registered in setup so it stands through the access phase
always @(posedge core_clk) begin
    if (srst) begin
        prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
        case (paddr)
            `PWT_OFS_TIMER3: prdata <= {{(32-WIDTH){1'b0}}, timer3};
            `PWT_OFS_TIMER4: prdata <= {{(32-WIDTH){1'b0}}, timer4};
            `PWT_OFS_MODE: prdata <= {24'h00_0000, timer_pair_b_mode_reg};
            `PWT_OFS_EDGE: prdata <= {24'h00_0000, edge_polarity_select_reg};
            `PWT_OFS_IRQ: prdata <= {28'h000_0000, irqReq};
            `PWT_OFS_IEN: prdata <= {28'h000_0000, irqEn};
            `PWT_OFS_PRESC: prdata <= {24'h00_0000, prescDiv};
            default: prdata <= 32'h0000_0000;
        endcase
    end
end

endmodule // pwt_timer

`default_nettype wire

// >>> include/pwt_consts.vh
/*
 * constants for the pulse-width measure and pwm timer block:
 * register byte offsets, field positions, reset values and codes.
 * assumes an apb slave with 32-bit data, one word per register.
 */
`ifndef PWT_CONSTS_VH
`define PWT_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PWT_OFS_TIMER3 12'h0000
`define PWT_OFS_TIMER4 12'h0004
`define PWT_OFS_MODE 12'h0008
`define PWT_OFS_EDGE 12'h000C
`define PWT_OFS_IRQ 12'h0010
`define PWT_OFS_IEN 12'h0014
`define PWT_OFS_PRESC 12'h0018

// ----------------------------------------------------------------
// mode register fields (timer_pair_b_mode_reg)
// ----------------------------------------------------------------
`define PWT_MODE_STOP3 2
`define PWT_MODE_STOP4 3
`define PWT_MODE_SRC4_LO 4
`define PWT_MODE_SRC4_HI 5
`define PWT_MODE_MEAS 6
`define PWT_MODE_PWM 7
`define PWT_MODE_SRC3 1
`define PWT_MODE_RST 8'h00

// count source codes for timer 4 (bits 5:4)
`define PWT_SRC4_T3OVF 2'h0
`define PWT_SRC4_PRESC 2'h1
`define PWT_SRC4_CNTR 2'h2
`define PWT_SRC4_T3OVF2 2'h3

// ----------------------------------------------------------------
// edge polarity register fields (edge_polarity_select_reg)
// ----------------------------------------------------------------
`define PWT_EDGE_A 2
`define PWT_EDGE_B 3
`define PWT_EDGE_MEASPIN 4
`define PWT_EDGE_RST 8'h00

// irq bits: 0 timer3, 1 timer4, 2 pin a, 3 pin b
`define PWT_IRQ_T3 0
`define PWT_IRQ_T4 1
`define PWT_IRQ_A 2
`define PWT_IRQ_B 3

`define PWT_TIMER_RST 8'hFF
`define PWT_PRESC_RST 8'h0F

`endif

// >>> sim/pulse_width_measure_and_pwm_timer_bench.sv
/*
 * self-checking bench for pwt_timer: apb traffic, pulse width
 * measurement on both pins, pwm widths. assumes model and checker.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwt_consts.vh"

module pulse_width_measure_and_pwm_timer_bench;
    logic core_clk, srst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata, v1;
    logic counter_pin_a, counter_pin_b, pwm_output_pin;
    logic [3:0] irqPending;
    bit onB, lvl;
    int numErrors = 0;
    int totalChecks = 0;
    int n;

    pwt_timer dut_u (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .counter_pin_a(counter_pin_a), .counter_pin_b(counter_pin_b),
        .pwm_output_pin(pwm_output_pin), .irqPending(irqPending));
    pwt_pulse_src src_u (.pinA(counter_pin_a), .pinB(counter_pin_b));

    // ----
    // clock and watchdog
    // ----
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // tests need about 2500 cycles; a hang is cut at 40000
    initial begin
        #2000000;
        numErrors++;
        conclude();
    end

    // ----
    // tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // cycles until the pwm pin leaves lvl
    task automatic span(input logic lvl);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (pwm_output_pin === lvl && n < 3000);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----
    // tests
    // ----
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        rd(`PWT_OFS_MODE);
        check(rdata, 32'h0);
        rd(12'h01C);
        check({rdata[30:0], err}, 32'h1);
        $display("test reset state done");
        wr(`PWT_OFS_IEN, 32'hF);
        wr(`PWT_OFS_MODE, 32'hC);
        wr(`PWT_OFS_TIMER3, 32'h40);
        wr(`PWT_OFS_MODE, 32'h8);
        repeat (61) @(posedge core_clk);
        wr(`PWT_OFS_MODE, 32'hC);
        rd(`PWT_OFS_TIMER3);
        check(rdata, 32'h3C);
        wr(`PWT_OFS_TIMER3, 32'h2);
        wr(`PWT_OFS_IRQ, 32'hF);
        wr(`PWT_OFS_MODE, 32'h8);
        n = 0;
        while (irqPending[0] !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        rd(`PWT_OFS_TIMER3);
        check(rdata, 32'h1);
        wr(`PWT_OFS_IEN, 32'h0);
        @(negedge core_clk);
        check(32'(irqPending), 32'h0);
        wr(`PWT_OFS_IEN, 32'hF);
        $display("test count and reload done");
        for (int k = 0; k < 4; k++) begin
            onB = k[1];
            lvl = k[0];
            // pin idles at the level that is not measured: lvl 0 counts high, 1 counts low
            src_u.drive(onB, lvl);
            wr(`PWT_OFS_EDGE, onB ? 32'h10 | 32'(lvl) << 3 : 32'(lvl) << 2);
            wr(`PWT_OFS_MODE, 32'h58);
            wr(`PWT_OFS_TIMER4, 32'hF0);
            wr(`PWT_OFS_IRQ, 32'hF);
            wr(`PWT_OFS_MODE, 32'h50);
            src_u.drive(onB, !lvl);
            #16000;
            src_u.drive(onB, lvl);
            repeat (10) @(posedge core_clk);
            rd(`PWT_OFS_TIMER4);
            v1 = rdata;
            check(32'((32'hF0 - v1) inside {[19:21]}), 32'h1);
            check(32'(irqPending[2 + onB]), 32'h1);
            // a second pulse must not count once the closing edge passed
            src_u.drive(onB, !lvl);
            #2400;
            src_u.drive(onB, lvl);
            repeat (10) @(posedge core_clk);
            rd(`PWT_OFS_TIMER4);
            check(rdata, v1);
        end
        $display("test measurement done");
        // pwm bit before timer values, timer 4 on prescaler
        wr(`PWT_OFS_MODE, 32'hC);
        wr(`PWT_OFS_MODE, 32'h9C);
        wr(`PWT_OFS_TIMER3, 32'h4);
        wr(`PWT_OFS_TIMER4, 32'h2);
        wr(`PWT_OFS_MODE, 32'h90);
        wr(`PWT_OFS_IRQ, 32'hF);
        @(negedge core_clk);
        check(32'(pwm_output_pin), 32'h0);
        span(1'b0);
        span(1'b1);
        span(1'b0);
        check(n, 32'h40);
        wr(`PWT_OFS_TIMER4, 32'h4);
        span(1'b1);
        check(n, 32'h1E);
        span(1'b0);
        check(n, 32'h40);
        span(1'b1);
        check(n, 32'h40);
        wr(`PWT_OFS_MODE, 32'h9C);
        @(negedge core_clk);
        v1 = 32'(pwm_output_pin);
        repeat (100) @(negedge core_clk);
        check(32'(pwm_output_pin), v1);
        $display("test pwm done");
        srst <= 1'b1;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        rd(`PWT_OFS_MODE);
        check(rdata, 32'h0);
        @(negedge core_clk);
        check(32'(pwm_output_pin), 32'h0);
        $display("test second reset done");
        conclude();
    end
endmodule // pulse_width_measure_and_pwm_timer_bench

bind pwt_timer pwt_assertions chk_u (.core_clk(core_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pwm_output_pin(pwm_output_pin), .irqPending(irqPending), .counter_pin_b(counter_pin_b));
`default_nettype wire

// >>> sim/pwt_assertions.sv
/*
 * checker for pwt_timer: pwm pin, request lines, reset state.
 * assumes it is bound to pwt_timer and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwt_consts.vh"

module pwt_assertions (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pwm_output_pin,
    input wire logic [3:0] irqPending,
    input wire logic counter_pin_b
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // ----
    // mode write tracking
    // ----
    logic modeWr;
    logic pwmOn;
    assign modeWr = psel && penable && pwrite && paddr == `PWT_OFS_MODE;
    // last written pwm bit; reset clears it as in the block
    always_ff @(posedge core_clk) begin
        if (srst)
            pwmOn <= 1'b0;
        else if (modeWr)
            pwmOn <= pwdata[`PWT_MODE_PWM];
    end
    sequence s_held;
        $stable(pwm_output_pin) [*8];
    endsequence
    // ----
    // properties
    // ----
    chk_reset_quiet: assert property ($fell(srst) |-> irqPending == 4'h0 && !pwm_output_pin)
        else $error("outputs not quiet after reset");
    chk_idle_no_wave: assert property (!pwmOn |-> !pwm_output_pin)
        else $error("pwm pin high outside pwm mode");
    chk_start_low: assert property (modeWr && pwdata[7] && !pwmOn |=> !pwm_output_pin)
        else $error("pwm did not start low");
    chk_stop_holds: assert property (modeWr && pwdata[3:2] == 2'b11 |=> ##1 s_held)
        else $error("pwm pin moved after stop");
    chk_t3_ovf_high: assert property ($rose(irqPending[0]) && pwmOn |-> ##[0:1] pwm_output_pin)
        else $error("timer 3 overflow did not raise pwm");
    chk_t4_ovf_low: assert property ($rose(irqPending[1]) && pwmOn |-> ##[0:1] !pwm_output_pin)
        else $error("timer 4 overflow did not lower pwm");
    chk_wave_in_pwm: assert property ($changed(pwm_output_pin) |-> pwmOn)
        else $error("pwm pin toggled outside pwm mode");
    // a request from pin b must lag the pin by the synchroniser
    chk_pin_synced: assert property ($rose(irqPending[3]) |-> $past(counter_pin_b, 2) != $past(counter_pin_b, 6))
        else $error("pin b request without a settled edge");
endmodule // pwt_assertions
`default_nettype wire

// >>> sim/pwt_pulse_src.sv
/*
 * far side of the timer pins: a pulse source on both counter pins.
 * assumes the bench calls drive; edges fall off the clock grid.
 */
`timescale 1ns/1ps
`default_nettype none

module pwt_pulse_src (
    output var logic pinA,
    output var logic pinB
);
    // ----
    // pin driver
    // ----
    // pins idle low so nothing fires before the bench asks
    initial begin
        pinA = 1'b0;
        pinB = 1'b0;
    end
    // a 7 ns skew keeps edges unrelated to core_clk
    task automatic drive(input bit onB, input bit lvl);
        #7;
        if (onB)
            pinB = lvl;
        else
            pinA = lvl;
    endtask
endmodule // pwt_pulse_src
`default_nettype wire
